// File: rtl/wos_map.svh
`ifndef WOS_MAP_SVH
`define WOS_MAP_SVH

// Register offsets (byte addresses, one word each)
`define WOS_REG_CTRL 8'h00
`define WOS_REG_CMD 8'h04
`define WOS_REG_START_SRC 8'h08
`define WOS_REG_PAUSE_SRC 8'h0c
`define WOS_REG_CLK_SRC 8'h10
`define WOS_REG_PERIOD 8'h14
`define WOS_REG_DELAY 8'h18
`define WOS_REG_COUNT 8'h1c
`define WOS_REG_DATA0 8'h20
`define WOS_REG_DATA1 8'h24
`define WOS_REG_FIFO_WR 8'h28
`define WOS_REG_STATUS 8'h2c
`define WOS_REG_DONE_CNT 8'h30

// Control register fields
`define WOS_CTRL_TIMING_LO 0
`define WOS_CTRL_REGEN_LO 2
`define WOS_CTRL_FINITE 4
`define WOS_CTRL_EXT_CLK 5
`define WOS_CTRL_CLK_FALL 6
`define WOS_CTRL_START_FALL 7
`define WOS_CTRL_PAUSE_LOW 8
`define WOS_CTRL_PAUSE_EN 9
`define WOS_CTRL_TRIG_EN 10

// Command register bits (write only, self clearing)
`define WOS_CMD_ARM 0
`define WOS_CMD_STOP 1
`define WOS_CMD_UPDATE 2
`define WOS_CMD_SW_PULSE 3
`define WOS_CMD_FLUSH 4

// Status register bits
`define WOS_STAT_UNDERFLOW 0
`define WOS_STAT_REFUSED 1
`define WOS_STAT_RUNNING 2
`define WOS_STAT_ARMED 3
`define WOS_STAT_FULL 4
`define WOS_STAT_EMPTY 5
`define WOS_STAT_LEVEL_LO 8

// Reset values
`define WOS_RST_CTRL 11'h000
`define WOS_RST_PERIOD 16'h0002
`define WOS_RST_DELAY 16'h0002
`define WOS_RST_COUNT 32'h0000_0001

// Timing: device clock and the sample timebase derived from it
`define WOS_CLK_HZ 40000000
`define WOS_TIMEBASE_HZ 20000000
`define WOS_TB_DIV (`WOS_CLK_HZ / `WOS_TIMEBASE_HZ)

`endif

// File: rtl/wos_pkg.sv
package wos_pkg;

  // Generation timing methods
  typedef enum logic [1:0] {
    WOS_TIME_SW = 2'h0,
    WOS_TIME_HW_DIRECT = 2'h1,
    WOS_TIME_HW_BUF = 2'h2
  } wos_timing_t;

  // Continuous data methods
  typedef enum logic [1:0] {
    WOS_REGEN_STD = 2'h0,
    WOS_REGEN_FIFO = 2'h1,
    WOS_REGEN_NONE = 2'h2
  } wos_regen_t;

  // Sequencer states, Gray coded along idle-armed-delay-run
  typedef enum logic [1:0] {
    WOS_IDLE = 2'b00,
    WOS_ARMED = 2'b01,
    WOS_DELAY = 2'b11,
    WOS_RUN = 2'b10
  } wos_state_t;

  // Digital trigger lines that feed every source selector
  typedef struct packed {
    logic star;
    logic in_start;
    logic in_stop;
    logic [7:0] backplane;
    logic [5:0] pft;
  } wos_lines_t;

  // One sample for both converter channels
  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } wos_sample_t;

  // Register port from software
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wos_bus_t;

endpackage

// File: rtl/wos_trig_sel.sv
`timescale 1ns/1ps
`default_nettype none

// Picks one trigger line, applies polarity, gives level and edge
module wos_trig_sel (
  input wire logic clk,
  input wire logic rst,
  input wire wos_pkg::wos_lines_t lines,
  input wire logic sw_pulse,
  input wire logic [4:0] sel,
  input wire logic invert,
  output logic level,
  output logic edge_pulse
);
  import wos_pkg::*;

  logic raw; // Selected line before polarity
  logic prev; // Last cycle's level, for edges

  // Source index: 0 software, 1-6 terminals, 7-14 backplane, 15 in stop,
  // 16 in start, 17 star; anything else reads as low before polarity
  always_comb begin
    raw = 1'b0;
    if (sel == 5'h00) begin
      raw = sw_pulse;
    end else if (sel <= 5'h06) begin
      raw = lines.pft[3'(sel - 5'h01)];
    end else if (sel <= 5'h0e) begin
      raw = lines.backplane[3'(sel - 5'h07)];
    end else if (sel == 5'h0f) begin
      raw = lines.in_stop;
    end else if (sel == 5'h10) begin
      raw = lines.in_start;
    end else if (sel == 5'h11) begin
      raw = lines.star;
    end
  end

  // Polarity selects falling edge or low level
  assign level = raw ^ invert;

  // Edge memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  // Active edge is a change to the active level
  assign edge_pulse = level & ~prev;

endmodule

`default_nettype wire

// File: rtl/wos_sequencer.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wos_map.svh"

// Contract
// R1: One sample clock updates both channels
// R2: Each sample clock applies one FIFO sample
// R3: One converter update per software command
// R4: Hardware timing from internal or external clock
// R5: Non-buffered mode writes data directly
// R6: Buffered samples leave FIFO one by one
// R7: Finite mode stops after configured count
// R8: Continuous mode runs until stop command
// R9: Standard regeneration accepts new data anytime
// R10: FIFO regeneration loads once, refuses writes
// R11: FIFO regeneration needs no host transfers
// R12: Non-regeneration never repeats; underflow flagged
// R13: Digital start and pause triggers only
// R14: Start trigger or software command starts
// R15: Start source selectable among listed lines
// R16: Start on rising or falling edge
// R17: Pause responds to level only
// R18: Pause skips next sample, never aborts
// R19: Update on rising or falling clock edge
// R20: Start-to-first-clock delay, default two ticks
// R21: Sample clocks ignored until armed
// R22: Sticky underflow on empty FIFO sample
module wos_sequencer #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire wos_pkg::wos_bus_t bus,
  output logic [31:0] rdata,
  input wire wos_pkg::wos_lines_t lines,
  output wos_pkg::wos_sample_t dac,
  output logic dac_update,
  output logic running
);
  import wos_pkg::*;

  // Configuration registers
  logic [10:0] ctrl;
  logic [4:0] start_src;
  logic [4:0] pause_src;
  logic [4:0] clk_src;
  logic [15:0] period; // Sample period in timebase ticks
  logic [15:0] delay; // Start to first sample, timebase ticks
  logic [31:0] count; // Finite sample count
  wos_sample_t direct; // Values for direct and software updates
  logic [31:0] done_cnt; // Samples produced this generation

  // Status
  logic underflow;
  logic refused;

  // Sequencer
  wos_state_t state;
  wos_state_t next_state;

  // FIFO storage in flip-flops
  wos_sample_t mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill; // Entries held
  logic [AW:0] replay; // Entries left in this replay pass

  // Timebase and divider
  logic [7:0] tb_cnt;
  logic tb_tick;
  logic [15:0] div_cnt;

  // Decoded fields
  wos_timing_t timing;
  wos_regen_t regen;
  logic is_wr;
  logic cmd_arm;
  logic cmd_stop;
  logic cmd_update;
  logic cmd_pulse;
  logic cmd_flush;
  logic start_edge;
  logic pause_lvl;
  logic ext_edge;
  logic paused;
  logic int_event;
  logic sample_event;
  logic fifo_empty;
  logic fifo_full;
  logic push;
  logic pop;
  logic fifo_locked;
  logic last_sample;

  // Address match for a write strobe
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign timing = wos_timing_t'(ctrl[`WOS_CTRL_TIMING_LO +: 2]);
  assign regen = wos_regen_t'(ctrl[`WOS_CTRL_REGEN_LO +: 2]);
  assign is_wr = bus.wr;
  assign cmd_arm = is_wr && hit(bus.addr, `WOS_REG_CMD) && bus.wdata[`WOS_CMD_ARM];
  assign cmd_stop = is_wr && hit(bus.addr, `WOS_REG_CMD) && bus.wdata[`WOS_CMD_STOP];
  assign cmd_update = is_wr && hit(bus.addr, `WOS_REG_CMD) && bus.wdata[`WOS_CMD_UPDATE];
  assign cmd_pulse = is_wr && hit(bus.addr, `WOS_REG_CMD) && bus.wdata[`WOS_CMD_SW_PULSE];
  assign cmd_flush = is_wr && hit(bus.addr, `WOS_REG_CMD) && bus.wdata[`WOS_CMD_FLUSH];

  // R13: start source is a digital line only
  // R15: selectable start source
  wos_trig_sel u_start (
    .clk(clk),
    .rst(rst),
    .lines(lines),
    .sw_pulse(cmd_pulse),
    .sel(start_src),
    .invert(ctrl[`WOS_CTRL_START_FALL]),
    .level(),
    .edge_pulse(start_edge)
  );

  // R17: pause uses the level output only
  wos_trig_sel u_pause (
    .clk(clk),
    .rst(rst),
    .lines(lines),
    .sw_pulse(1'b0),
    .sel(pause_src),
    .invert(ctrl[`WOS_CTRL_PAUSE_LOW]),
    .level(pause_lvl),
    .edge_pulse()
  );

  // R4: external sample clock source
  // R19: invert picks the falling edge
  wos_trig_sel u_clk (
    .clk(clk),
    .rst(rst),
    .lines(lines),
    .sw_pulse(1'b0),
    .sel(clk_src),
    .invert(ctrl[`WOS_CTRL_CLK_FALL]),
    .level(),
    .edge_pulse(ext_edge)
  );

  assign paused = ctrl[`WOS_CTRL_PAUSE_EN] && pause_lvl;

  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `WOS_RST_CTRL;
      start_src <= 5'h00;
      pause_src <= 5'h00;
      clk_src <= 5'h00;
      period <= `WOS_RST_PERIOD;
      delay <= `WOS_RST_DELAY;
      count <= `WOS_RST_COUNT;
      direct <= '0;
    end else if (is_wr) begin
      // Config is plain storage; changing it mid-run takes effect at once
      unique case (bus.addr)
        `WOS_REG_CTRL: ctrl <= bus.wdata[10:0];
        `WOS_REG_START_SRC: start_src <= bus.wdata[4:0];
        `WOS_REG_PAUSE_SRC: pause_src <= bus.wdata[4:0];
        `WOS_REG_CLK_SRC: clk_src <= bus.wdata[4:0];
        `WOS_REG_PERIOD: period <= bus.wdata[15:0];
        `WOS_REG_DELAY: delay <= bus.wdata[15:0];
        `WOS_REG_COUNT: count <= bus.wdata;
        `WOS_REG_DATA0: direct.ch0 <= bus.wdata[15:0];
        `WOS_REG_DATA1: direct.ch1 <= bus.wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Timebase tick, one cycle enable from the device clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tb_cnt <= 8'h00;
    end else if (tb_cnt == 8'(`WOS_TB_DIV - 1)) begin
      tb_cnt <= 8'h00;
    end else begin
      tb_cnt <= tb_cnt + 8'h01;
    end
  end
  assign tb_tick = tb_cnt == 8'(`WOS_TB_DIV - 1);

  // Internal clock divider; holds while paused in run, so the period resumes where it stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 16'h0000;
    end else if (state == WOS_IDLE || state == WOS_ARMED) begin
      div_cnt <= 16'h0000;
    end else if (tb_tick && !(state == WOS_RUN && paused)) begin
      // R20: first pulse after the delay, then one per period
      if (state == WOS_DELAY && div_cnt == delay - 16'h0001) begin
        div_cnt <= 16'h0000;
      end else if (state == WOS_RUN && div_cnt == period - 16'h0001) begin
        div_cnt <= 16'h0000;
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // Internal clock event; a zero delay or period acts as one tick
  assign int_event = tb_tick && (state == WOS_DELAY || (state == WOS_RUN && !paused))
    && (div_cnt == (state == WOS_DELAY ? delay : period) - 16'h0001
    || (state == WOS_DELAY ? delay : period) == 16'h0000);

  // R21: events count only once armed and running
  // R18: pause masks every sample while its level is active
  assign sample_event = (timing != WOS_TIME_SW) && !paused && (ctrl[`WOS_CTRL_EXT_CLK]
    ? (state == WOS_RUN && ext_edge) : (int_event));

  assign last_sample = ctrl[`WOS_CTRL_FINITE] && done_cnt + 32'h1 >= count;

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      WOS_IDLE: begin
        // R14: trigger waits, otherwise command starts
        if (cmd_arm && timing != WOS_TIME_SW) begin
          if (ctrl[`WOS_CTRL_TRIG_EN]) begin
            next_state = WOS_ARMED;
          end else begin
            next_state = ctrl[`WOS_CTRL_EXT_CLK] ? WOS_RUN : WOS_DELAY;
          end
        end
      end
      WOS_ARMED: begin
        // R16: edge chosen by start polarity
        if (start_edge) begin
          next_state = ctrl[`WOS_CTRL_EXT_CLK] ? WOS_RUN : WOS_DELAY;
        end
      end
      WOS_DELAY: begin
        // Delayed first pulse is itself a sample
        if (sample_event) begin
          next_state = last_sample ? WOS_IDLE : WOS_RUN;
        end else if (int_event) begin
          next_state = WOS_RUN;
        end
      end
      WOS_RUN: begin
        // R7: finite generation ends on the last sample
        if (sample_event && last_sample) begin
          next_state = WOS_IDLE;
        end
      end
    endcase
    // R8: continuous runs until stopped
    if (cmd_stop) begin
      next_state = WOS_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= WOS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Sample counter, cleared by an arm command while idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_cnt <= 32'h0;
    end else if (cmd_arm && state == WOS_IDLE) begin
      done_cnt <= 32'h0;
    end else if (sample_event) begin
      done_cnt <= done_cnt + 32'h1;
    end
  end

  assign running = state != WOS_IDLE;

  // FIFO control
  assign fifo_empty = fill == '0;
  assign fifo_full = fill == (AW+1)'(DEPTH);
  // R10: no writes into a replaying FIFO
  assign fifo_locked = running && regen == WOS_REGEN_FIFO;
  assign push = is_wr && hit(bus.addr, `WOS_REG_FIFO_WR) && !fifo_full && !fifo_locked;
  // R6: buffered mode draws one sample per event
  assign pop = sample_event && timing == WOS_TIME_HW_BUF && !fifo_empty;

  // FIFO storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= bus.wdata;
    end
  end

  // FIFO pointers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
      replay <= '0;
    end else if (cmd_flush && !running) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
      replay <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
      end
      if (cmd_arm && state == WOS_IDLE) begin
        replay <= fill;
      end else if (pop && regen == WOS_REGEN_FIFO) begin
        // R11: replay in place, wrap to the oldest held sample
        if (replay == (AW+1)'(1)) begin
          rd_ptr <= AW'((rd_ptr + DEPTH - int'(fill) + 1) % DEPTH);
          replay <= fill;
        end else begin
          rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
          replay <= replay - 1'b1;
        end
      end else if (pop) begin
        // R9: standard regeneration consumes; host refills freely
        // R12: consumed samples are gone, never repeated
        rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
      end
      if (push && !(pop && regen != WOS_REGEN_FIFO)) begin
        fill <= fill + 1'b1;
      end else if (!push && pop && regen != WOS_REGEN_FIFO) begin
        fill <= fill - 1'b1;
      end
    end
  end

  // Converter outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac <= '0;
      dac_update <= 1'b0;
    end else begin
      dac_update <= 1'b0;
      if (timing == WOS_TIME_SW && cmd_update) begin
        // R3: one update per command
        dac <= direct;
        dac_update <= 1'b1;
      end else if (sample_event && timing == WOS_TIME_HW_DIRECT) begin
        // R5: direct values bypass the FIFO
        dac <= direct;
        dac_update <= 1'b1;
      end else if (pop) begin
        // R1: both channels load together
        // R2: one FIFO sample per clock
        dac <= mem[rd_ptr];
        dac_update <= 1'b1;
      end
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      underflow <= 1'b0;
      refused <= 1'b0;
    end else begin
      // R22: empty at a sample event
      if (sample_event && timing == WOS_TIME_HW_BUF && fifo_empty) begin
        underflow <= 1'b1;
      end else if (is_wr && hit(bus.addr, `WOS_REG_STATUS)
          && bus.wdata[`WOS_STAT_UNDERFLOW]) begin
        underflow <= 1'b0;
      end
      if (is_wr && hit(bus.addr, `WOS_REG_FIFO_WR) && !push) begin
        refused <= 1'b1;
      end else if (is_wr && hit(bus.addr, `WOS_REG_STATUS)
          && bus.wdata[`WOS_STAT_REFUSED]) begin
        refused <= 1'b0;
      end
    end
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `WOS_REG_CTRL: rdata <= {21'h0, ctrl};
        `WOS_REG_START_SRC: rdata <= {27'h0, start_src};
        `WOS_REG_PAUSE_SRC: rdata <= {27'h0, pause_src};
        `WOS_REG_CLK_SRC: rdata <= {27'h0, clk_src};
        `WOS_REG_PERIOD: rdata <= {16'h0, period};
        `WOS_REG_DELAY: rdata <= {16'h0, delay};
        `WOS_REG_COUNT: rdata <= count;
        `WOS_REG_DATA0: rdata <= {16'h0, direct.ch0};
        `WOS_REG_DATA1: rdata <= {16'h0, direct.ch1};
        `WOS_REG_STATUS: rdata <= {(23-AW)'(0), fill, 2'h0, fifo_empty, fifo_full,
          state == WOS_ARMED, running, refused, underflow};
        `WOS_REG_DONE_CNT: rdata <= done_cnt;
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

endmodule

`default_nettype wire

// File: dv/wos_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "wos_map.svh"

// Port-level checker for the output sequencer
module wos_seq_asserts #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire wos_pkg::wos_bus_t bus,
  input wire logic [31:0] rdata,
  input wire wos_pkg::wos_lines_t lines,
  input wire wos_pkg::wos_sample_t dac,
  input wire logic dac_update,
  input wire logic running
);
  import wos_pkg::*;
  logic [1:0] timing; // Shadow of the timing field
  logic cmd_wr; // Command write this cycle
  logic sw_cmd; // Software update command this cycle
  assign cmd_wr = bus.wr && (bus.addr == `WOS_REG_CMD);
  assign sw_cmd = cmd_wr && bus.wdata[`WOS_CMD_UPDATE];

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Track the timing method, since most checks depend on it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timing <= 2'h0;
    end else if (bus.wr && (bus.addr == `WOS_REG_CTRL)) begin
      timing <= bus.wdata[1:0];
    end
  end

  AST_RESET_QUIET:
    assert property ($fell(rst) |-> !running && !dac_update && rdata == 32'h0)
    else $error("outputs not quiet after reset");
  AST_RDATA_STANDS:
    assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  AST_DAC_HOLD:
    assert property (!dac_update |-> $stable(dac))
    else $error("converter codes moved without an update");
  AST_SW_UPDATE:
    assert property (sw_cmd && timing == 2'h0 |=> dac_update)
    else $error("software update command gave no update");
  AST_SW_ONLY:
    assert property (timing == 2'h0 && !running && !$past(running) && !$past(sw_cmd)
      |-> !dac_update)
    else $error("software timed update without a command");
  AST_IDLE_QUIET:
    assert property (timing != 2'h0 && !running && !$past(running) |-> !dac_update)
    else $error("update while generation idle");
  AST_ARM_RUN:
    assert property (cmd_wr && bus.wdata[`WOS_CMD_ARM] && !running && timing != 2'h0
      |=> running)
    else $error("arm command did not start sequencing");
  AST_STOP:
    assert property (cmd_wr && bus.wdata[`WOS_CMD_STOP] |-> ##[1:4] !running)
    else $error("stop command did not end generation");
  AST_UPD_SPACING:
    assert property (timing != 2'h0 && dac_update |=> !dac_update)
    else $error("hardware timed updates too close");
endmodule

bind wos_sequencer wos_seq_asserts #(.DEPTH(DEPTH), .AW(AW)) i_wos_seq_asserts (
  .clk(clk),
  .rst(rst),
  .bus(bus),
  .rdata(rdata),
  .lines(lines),
  .dac(dac),
  .dac_update(dac_update),
  .running(running)
);

`default_nettype wire

// File: dv/wos_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "wos_map.svh"

// Host memory pushing a block of samples into the FIFO
module wos_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] cnt,
  input wire logic [15:0] base,
  output wos_pkg::wos_bus_t hbus
);
  import wos_pkg::*;
  logic [3:0] left; // Samples still to send
  logic [15:0] idx; // Next sample code

  // One write per cycle, back to back, as the port allows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left <= 4'h0;
      idx <= 16'h0;
      hbus <= '0;
    end else if (go) begin
      left <= cnt;
      idx <= base;
      hbus.wr <= 1'b0;
    end else if (left != 4'h0) begin
      hbus <= '{addr: `WOS_REG_FIFO_WR, wdata: {~idx, idx}, wr: 1'b1, rd: 1'b0};
      left <= left - 4'h1;
      idx <= idx + 16'h1;
    end else begin
      // Idle data keeps changing so nothing leans on stale values
      hbus.wr <= 1'b0;
      hbus.wdata <= ~hbus.wdata;
    end
  end
endmodule

`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wos_map.svh"

// Self-checking bench for the output sequencer
module testbench;
  import wos_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] e;} wos_row_t; // Address, expected read
  logic clk; // 40 MHz clock
  logic rst; // Async reset
  wos_bus_t tb_bus; // Bench side of the port
  wos_bus_t h_bus; // Host side of the port
  wos_bus_t bus; // Merged port
  logic [31:0] rdata;
  wos_lines_t lines; // Trigger lines
  wos_sample_t dac;
  logic dac_update;
  logic running;
  logic go;
  logic [3:0] cnt;
  logic [15:0] base;
  wos_sample_t seen[$]; // Samples the converters took
  wos_row_t rows[7];
  int fails = 0;
  int samples_checked = 0;
  int n0;
  logic [31:0] v;

  // Host owns the port only while it writes
  assign bus = h_bus.wr ? h_bus : tb_bus;

  wos_sequencer #(.DEPTH(16), .AW(4)) i_wos_sequencer (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .lines(lines), .dac(dac), .dac_update(dac_update), .running(running));
  wos_host_model i_wos_host_model (.clk(clk), .rst(rst), .go(go), .cnt(cnt), .base(base),
    .hbus(h_bus));

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Record every update
  always @(posedge clk) begin
    if (dac_update === 1'b1) seen.push_back(dac);
  end

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tb_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    tb_bus.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    tb_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    tb_bus.rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask

  // Host fills the FIFO, then settles
  task automatic load(input logic [3:0] n, input logic [15:0] b);
    cnt <= n;
    base <= b;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  task automatic idle_wait();
    for (int i = 0; i < 400 && running !== 1'b0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("running", {31'h0, running}, 32'h0);
  endtask

  function automatic wos_sample_t word(input logic [15:0] b);
    return {~b, b};
  endfunction

  task automatic end_sim();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    tb_bus = '0;
    lines = '0;
    go = 1'b0;
    cnt = 4'h0;
    base = 16'h0;
    rows = '{'{`WOS_REG_CTRL, 32'h0}, '{`WOS_REG_PERIOD, 32'h2}, '{`WOS_REG_DELAY, 32'h2},
      '{`WOS_REG_COUNT, 32'h1}, '{`WOS_REG_STATUS, 32'h20}, '{`WOS_REG_DONE_CNT, 32'h0},
      '{8'h3c, 32'h0}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("dac_rst", dac, 32'h0);
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      chk("reg", v, rows[i].e);
    end
    // Software timed single update
    wr(`WOS_REG_DATA0, 32'h1234);
    wr(`WOS_REG_DATA1, 32'habcd);
    n0 = seen.size();
    wr(`WOS_REG_CMD, 32'h4);
    repeat (4) @(posedge clk);
    chk("sw_count", seen.size() - n0, 1);
    chk("sw_dac", seen[$], 32'habcd1234);
    // Buffered finite run of three
    load(4'h3, 16'h0100);
    wr(`WOS_REG_COUNT, 32'h3);
    wr(`WOS_REG_CTRL, 32'h12);
    n0 = seen.size();
    wr(`WOS_REG_CMD, 32'h1);
    // Two timebase ticks must pass before the first sample shows
    repeat (2) @(posedge clk);
    chk("delay_quiet", seen.size() - n0, 0);
    idle_wait();
    chk("fin_count", seen.size() - n0, 3);
    for (int k = 0; k < 3; k++) chk("fin_dac", seen[n0 + k], word(16'(16'h0100 + k)));
    // Continuous, no regeneration, runs dry
    load(4'h2, 16'h0200);
    wr(`WOS_REG_CTRL, 32'h0a);
    n0 = seen.size();
    wr(`WOS_REG_CMD, 32'h1);
    repeat (60) @(posedge clk);
    chk("cont_run", {31'h0, running}, 32'h1);
    rd(`WOS_REG_STATUS, v);
    chk("underflow", {31'h0, v[0]}, 32'h1);
    chk("no_repeat", seen.size() - n0, 2);
    wr(`WOS_REG_CMD, 32'h2);
    idle_wait();
    wr(`WOS_REG_STATUS, 32'h1);
    rd(`WOS_REG_STATUS, v);
    chk("uf_clear", {31'h0, v[0]}, 32'h0);
    // FIFO regeneration replays and refuses writes
    load(4'h2, 16'h0300);
    wr(`WOS_REG_CTRL, 32'h06);
    n0 = seen.size();
    wr(`WOS_REG_CMD, 32'h1);
    repeat (40) @(posedge clk);
    wr(`WOS_REG_FIFO_WR, 32'h0);
    rd(`WOS_REG_STATUS, v);
    chk("refused", {31'h0, v[1]}, 32'h1);
    chk("replay0", seen[n0 + 2], word(16'h0300));
    chk("replay1", seen[n0 + 3], word(16'h0301));
    wr(`WOS_REG_CMD, 32'h2);
    idle_wait();
    wr(`WOS_REG_CMD, 32'h10);
    // Pause held by level on terminal 1
    wr(`WOS_REG_PAUSE_SRC, 32'h2);
    load(4'h1, 16'h0500);
    lines <= 17'h2;
    wr(`WOS_REG_CTRL, 32'h206);
    n0 = seen.size();
    wr(`WOS_REG_CMD, 32'h1);
    repeat (40) @(posedge clk);
    chk("paused", seen.size() - n0, 0);
    lines <= '0;
    repeat (40) @(posedge clk);
    chk("resumed", {31'h0, seen.size() > n0}, 32'h1);
    wr(`WOS_REG_CMD, 32'h2);
    idle_wait();
    wr(`WOS_REG_CMD, 32'h10);
    // Every start source, alternating edge
    wr(`WOS_REG_COUNT, 32'h1);
    for (int s = 0; s < 18; s++) begin
      load(4'h1, 16'(16'h0600 + s));
      lines <= s[0] ? '1 : '0;
      wr(`WOS_REG_START_SRC, 32'(s));
      wr(`WOS_REG_CTRL, 32'h412 | (s[0] ? 32'h80 : 32'h0));
      n0 = seen.size();
      wr(`WOS_REG_CMD, 32'h1);
      repeat (20) @(posedge clk);
      chk("armed_quiet", seen.size() - n0, 0);
      if (s == 0) wr(`WOS_REG_CMD, 32'h8);
      else lines <= s[0] ? ~(17'h1 << (s - 1)) : (17'h1 << (s - 1));
      idle_wait();
      chk("trig_dac", seen[$], word(16'(16'h0600 + s)));
    end
    // Direct values on an external clock, falling edge of terminal 0
    wr(`WOS_REG_CLK_SRC, 32'h1);
    wr(`WOS_REG_DATA0, 32'h5a5a);
    lines <= 17'h1;
    wr(`WOS_REG_CTRL, 32'h61);
    n0 = seen.size();
    wr(`WOS_REG_CMD, 32'h1);
    repeat (10) @(posedge clk);
    chk("ext_quiet", seen.size() - n0, 0);
    lines <= 17'h0;
    repeat (4) @(posedge clk);
    // Rising edge must not update while the falling edge is chosen
    lines <= 17'h1;
    repeat (4) @(posedge clk);
    chk("ext_count", seen.size() - n0, 1);
    chk("ext_dac", seen[$], 32'habcd5a5a);
    // Reset in mid-run clears the generation and the converter codes
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("rst_run", {31'h0, running}, 32'h0);
    chk("rst_dac", dac, 32'h0);
    end_sim();
  end

  // Watchdog
  initial begin
    #1000000;
    fails++;
    end_sim();
  end
endmodule

`default_nettype wire
